// file: rtl/cpu_decode_params.svh
// constants for the operand and bus cycle decoder: flag positions, reset values, vector page
// assumes a 16-bit address space with the vector table on the top page
`ifndef CPU_DECODE_PARAMS_SVH
`define CPU_DECODE_PARAMS_SVH

// ----------------------------------------
// condition flag positions
// ----------------------------------------
`define FLG_C 0
`define FLG_Z 1
`define FLG_N 2
`define FLG_I 3
`define FLG_H 4
`define FLG_V 7

// ----------------------------------------
// reset values and fixed codes
// ----------------------------------------
`define FLG_RESET 8'h68
`define SP_RESET 16'h00FF
`define VEC_PAGE 8'hFF
`define VEC_RESET 8'hFE
`define VEC_SWI 8'hFC
`define VEC_IRQ 8'hFA
`define OPC_PAGE2 8'h9E
`define OPC_SWI 8'h83

`endif

// file: rtl/cpu_decode_pkg.sv
// types shared by the operand and bus cycle decoder
// assumes the params header sits beside it
`default_nettype none

package cpu_decode_pkg;

    typedef enum logic [3:0] {
        no_operand_mode = 4'b0000,
        operand_in_opcode_mode = 4'b0001,
        direct_page_mode = 4'b0010,
        full_address_mode = 4'b0011,
        indexed_plain_mode = 4'b0100,
        indexed_byte_offset_mode = 4'b0101,
        indexed_word_offset_mode = 4'b0110,
        indexed_post_increment_mode = 4'b0111,
        indexed_byte_offset_post_increment_mode = 4'b1000,
        stack_byte_offset_mode = 4'b1001,
        stack_word_offset_mode = 4'b1010,
        relative_mode = 4'b1011
    } mode_t;

    typedef enum logic [3:0] {
        C_NONE = 4'b0000, C_ALU = 4'b0001, C_STORE = 4'b0010, C_JMP = 4'b0011,
        C_JSR = 4'b0100, C_BRA = 4'b0101, C_CBEQ = 4'b0110, C_PSH = 4'b0111,
        C_PUL = 4'b1000, C_SWI = 4'b1001, C_WAIT = 4'b1010, C_FLAG = 4'b1011
    } op_class_t;

    typedef enum logic [3:0] {
        S_FETCH = 4'b0000, S_OPND = 4'b0001, S_READ = 4'b0010, S_WRITE = 4'b0011,
        S_PUSH = 4'b0100, S_POP = 4'b0101, S_VECHI = 4'b0110, S_VECLO = 4'b0111,
        S_FREE = 4'b1000, S_WAIT = 4'b1001
    } state_t;

    typedef enum logic [2:0] {
        CYC_FREE = 3'b000, CYC_FETCH = 3'b001, CYC_READ = 3'b010, CYC_WRITE = 3'b011,
        CYC_PUSH = 3'b100, CYC_POP = 3'b101, CYC_VECTOR = 3'b110
    } cycle_t;

    typedef struct packed {
        op_class_t cls;
        mode_t mode;
        logic [2:0] len;
        logic [3:0] cycles;
    } decode_t;

    typedef struct packed {
        logic [15:0] addr;
        logic [7:0] wdata;
        cycle_t code;
        logic rd;
        logic wr;
    } busReq_t;

endpackage : cpu_decode_pkg

`default_nettype wire

// file: rtl/cpu_operand_and_bus_cycle_decode.sv
// 8-bit core sequencer: opcode decode, operand addressing and one bus cycle per clock
// assumes memory answers busRdata combinationally in the cycle of the request
//
// Behaviour
// [RULE1] indexed no-offset post-increment mode uses H:X then adds one to H:X after the access.
// [RULE2] indexed byte-offset post-increment mode adds an unsigned byte to H:X, then bumps H:X.
// [RULE3] indexed modes exist with no offset, a byte offset and a word offset added to H:X.
// [RULE4] stack modes add a byte or a word offset to the stack pointer.
// [RULE5] a free cycle is one clock long and is signalled as a read.
// [RULE6] a program fetch reads the byte at the program counter, which then advances by one.
// [RULE7] an operand read moves one byte from the addressed location into the core.
// [RULE8] an operand write drives one byte from the core to the addressed location.
// [RULE9] a push writes one byte at the stack pointer.
// [RULE10] a pop reads one byte from the stack area just above the stack pointer.
// [RULE11] vector fetches read the top address page, high byte first then low byte.
// [RULE12] relative branches add a signed byte (-128..+127) to the next instruction address.
// [RULE13] the wait instruction clears the interrupt mask and halts until an interrupt.
// [RULE14] each opcode decodes to class, addressing mode, length and cycle count.
// [RULE15] the flags register holds V, H, I, N, Z and C, updated per instruction.
`include "cpu_decode_params.svh"
`default_nettype none

module cpu_operand_and_bus_cycle_decode import cpu_decode_pkg::*; (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic [7:0] busRdata,
    input wire logic irqReq,
    output var busReq_t busOut,
    output var decode_t decodeOut,
    output logic [7:0] flagsOut,
    output logic halted
);

    // ----------------------------------------
    // opcode map
    // ----------------------------------------
    function automatic decode_t decodeOp(input logic pg2, input logic [7:0] opc);
        decode_t d;
        op_class_t mc;
        logic [3:0] hi;
        logic [3:0] lo;
        hi = opc[7:4];
        lo = opc[3:0];
        d = '{C_NONE, no_operand_mode, 3'd1, 4'd1};
        mc = (lo == 4'h7 || lo == 4'hF) ? C_STORE : (lo == 4'hC) ? C_JMP :
             (lo == 4'hD) ? C_JSR : C_ALU;
        if (pg2) begin
            if (hi == 4'hE && (mc == C_ALU || mc == C_STORE)) begin
                d = '{mc, stack_byte_offset_mode, 3'd3, 4'd4}; // [RULE4]
            end else if (hi == 4'hD && (mc == C_ALU || mc == C_STORE)) begin
                d = '{mc, stack_word_offset_mode, 3'd4, 4'd5}; // [RULE4]
            end
        end else begin
            case (hi)
                4'h2: d = '{C_BRA, relative_mode, 3'd2, 4'd3};
                4'h6: if (lo == 4'h1) d = '{C_CBEQ, indexed_byte_offset_post_increment_mode,
                                            3'd3, 4'd5}; // [RULE2]
                4'h7: if (lo == 4'h1) d = '{C_CBEQ, indexed_post_increment_mode,
                                            3'd2, 4'd5}; // [RULE1]
                4'h8: begin
                    case (lo)
                        4'h3: d = '{C_SWI, no_operand_mode, 3'd1, 4'd11};
                        4'h6, 4'h8: d = '{C_PUL, no_operand_mode, 3'd1, 4'd3};
                        4'h7, 4'h9: d = '{C_PSH, no_operand_mode, 3'd1, 4'd2};
                        4'hF: d = '{C_WAIT, no_operand_mode, 3'd1, 4'd2};
                        default: d = d;
                    endcase
                end
                4'h9: if (lo == 4'h7 || lo[3] && lo != 4'hC && lo != 4'hE)
                          d = '{C_FLAG, no_operand_mode, 3'd1, 4'd1};
                4'hA: if (mc == C_ALU) d = '{C_ALU, operand_in_opcode_mode, 3'd2, 4'd2};
                4'hB: d = '{mc, direct_page_mode, 3'd2, 4'd3};
                4'hC: d = '{mc, full_address_mode, 3'd3, 4'd4};
                4'hD: d = '{mc, indexed_word_offset_mode, 3'd3, 4'd4}; // [RULE3]
                4'hE: d = '{mc, indexed_byte_offset_mode, 3'd2, 4'd3}; // [RULE3]
                4'hF: d = '{mc, indexed_plain_mode, 3'd1, 4'd3}; // [RULE3]
                default: d = d;
            endcase
            if (hi >= 4'hB && mc == C_JSR) d.cycles = d.cycles + 4'd2;
            if (hi == 4'hF && mc == C_STORE) d.cycles = 4'd2;
        end
        return d;
    endfunction : decodeOp

    // ----------------------------------------
    // state
    // ----------------------------------------
    state_t st_q, stNext, dispSt, finishSt;
    decode_t info_q, dec, cur;
    logic [15:0] pc_q, hx_q, sp_q, ea;
    logic [7:0] a_q, flg_q, opc_q, op1_q, op2_q, lastOp_q, vecLo_q;
    logic [2:0] opLeft_q, nOps, pushIdx_q, pushLast_q;
    logic [3:0] cyc_q, doneCnt;
    logic page2_q, intr_q, jumpPend_q, takeIrq, isPrefix, brTaken, aluGo, cbeqEq;

    assign dec = decodeOp(page2_q, busRdata); // [RULE14]
    assign cur = (st_q == S_FETCH) ? dec : info_q;
    assign takeIrq = st_q == S_FETCH && !page2_q && irqReq && !flg_q[`FLG_I];
    assign isPrefix = st_q == S_FETCH && !page2_q && !takeIrq && busRdata == `OPC_PAGE2;
    assign nOps = dec.len - 3'd1 - {2'b00, page2_q};
    assign doneCnt = (st_q == S_FETCH && !page2_q) ? 4'd1 : cyc_q + 4'd1;
    // short instructions pad with free cycles so the total matches the decoded count
    assign finishSt = (doneCnt >= cur.cycles) ? S_FETCH : S_FREE; // [RULE14]

    always_comb begin
        unique case (cur.cls)
            C_ALU: dispSt = (cur.mode == operand_in_opcode_mode) ? finishSt : S_READ;
            C_CBEQ: dispSt = S_READ;
            C_STORE: dispSt = S_WRITE;
            C_JMP: dispSt = S_FREE;
            C_JSR, C_PSH, C_SWI: dispSt = S_PUSH;
            C_PUL: dispSt = S_POP;
            C_WAIT: dispSt = S_WAIT;
            default: dispSt = finishSt;
        endcase
    end

    always_comb begin
        unique case (st_q)
            S_FETCH: stNext = takeIrq ? S_PUSH : isPrefix ? S_FETCH :
                              (nOps == 3'd0) ? dispSt : S_OPND;
            S_OPND: stNext = (opLeft_q == 3'd1) ? dispSt : S_OPND;
            S_PUSH: stNext = (pushIdx_q != pushLast_q) ? S_PUSH :
                             (intr_q || info_q.cls == C_SWI) ? S_VECHI : finishSt;
            S_VECHI: stNext = S_VECLO;
            S_WAIT: stNext = irqReq ? S_FETCH : S_WAIT; // [RULE13]
            default: stNext = finishSt;
        endcase
    end

    // ----------------------------------------
    // effective address and branch test
    // ----------------------------------------
    always_comb begin
        unique case (info_q.mode)
            direct_page_mode: ea = {8'h00, op1_q};
            full_address_mode: ea = {op1_q, op2_q};
            indexed_plain_mode, indexed_post_increment_mode: ea = hx_q; // [RULE1] [RULE3]
            indexed_byte_offset_mode, indexed_byte_offset_post_increment_mode:
                ea = hx_q + {8'h00, op1_q}; // [RULE2] [RULE3]
            indexed_word_offset_mode: ea = hx_q + {op1_q, op2_q}; // [RULE3]
            stack_byte_offset_mode: ea = sp_q + {8'h00, op1_q}; // [RULE4]
            stack_word_offset_mode: ea = sp_q + {op1_q, op2_q}; // [RULE4]
            default: ea = pc_q;
        endcase
    end

    always_comb begin
        unique case (opc_q[3:0])
            4'h0: brTaken = 1'b1;
            4'h1: brTaken = 1'b0;
            4'h2: brTaken = !(flg_q[`FLG_C] || flg_q[`FLG_Z]);
            4'h3: brTaken = flg_q[`FLG_C] || flg_q[`FLG_Z];
            4'h4: brTaken = !flg_q[`FLG_C];
            4'h5: brTaken = flg_q[`FLG_C];
            4'h6: brTaken = !flg_q[`FLG_Z];
            4'h7: brTaken = flg_q[`FLG_Z];
            4'h8: brTaken = !flg_q[`FLG_H];
            4'h9: brTaken = flg_q[`FLG_H];
            4'hA: brTaken = !flg_q[`FLG_N];
            4'hB: brTaken = flg_q[`FLG_N];
            4'hC: brTaken = !flg_q[`FLG_I];
            4'hD: brTaken = flg_q[`FLG_I];
            4'hE: brTaken = irqReq;
            4'hF: brTaken = !irqReq;
        endcase
    end

    // ----------------------------------------
    // arithmetic on the operand byte
    // ----------------------------------------
    logic [7:0] src, mm, res;
    logic [8:0] sum;
    logic [4:0] hsum;
    logic isSub, arith, cin;
    assign isSub = opc_q[3:0] <= 4'h3;
    assign arith = isSub || opc_q[3:0] == 4'h9 || opc_q[3:0] == 4'hB;
    assign src = (opc_q[3:0] == 4'h3 || opc_q[3:0] == 4'hE) ? hx_q[7:0] : a_q;
    assign mm = isSub ? ~busRdata : busRdata;
    assign cin = (opc_q[3:0] == 4'h2) ? !flg_q[`FLG_C] :
                 (opc_q[3:0] == 4'h9) ? flg_q[`FLG_C] : isSub;
    assign sum = {1'b0, src} + {1'b0, mm} + {8'h00, cin};
    assign hsum = {1'b0, src[3:0]} + {1'b0, mm[3:0]} + {4'h0, cin};
    always_comb begin
        unique case (opc_q[3:0])
            4'h4, 4'h5: res = src & busRdata;
            4'h8: res = src ^ busRdata;
            4'hA: res = src | busRdata;
            4'h6, 4'hE: res = busRdata;
            default: res = sum[7:0];
        endcase
    end
    assign aluGo = info_q.cls == C_ALU && (st_q == S_READ ||
                   (st_q == S_OPND && opLeft_q == 3'd1 && info_q.mode == operand_in_opcode_mode));
    assign cbeqEq = sum[7:0] == 8'h00;

    // ----------------------------------------
    // sequencing
    // ----------------------------------------
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            st_q <= S_VECHI;
            info_q <= '{C_NONE, no_operand_mode, 3'd1, 4'd1};
            cyc_q <= 4'h0;
            page2_q <= 1'b0;
            intr_q <= 1'b0;
            opc_q <= 8'h00;
            opLeft_q <= 3'd0;
            vecLo_q <= `VEC_RESET;
        end else begin
            st_q <= stNext;
            cyc_q <= doneCnt;
            if (st_q == S_FETCH) begin
                page2_q <= isPrefix;
                intr_q <= takeIrq;
                opLeft_q <= nOps;
                if (takeIrq) begin
                    info_q <= decodeOp(1'b0, `OPC_SWI);
                    vecLo_q <= `VEC_IRQ;
                end else if (!isPrefix) begin
                    info_q <= dec;
                    opc_q <= busRdata;
                    vecLo_q <= `VEC_SWI;
                end
            end
            if (st_q == S_OPND) opLeft_q <= opLeft_q - 3'd1;
        end
    end

    // page-2 forms spent one length byte on the prefix, which page2_q no longer shows
    logic [2:0] nOpsInfo;
    assign nOpsInfo = info_q.len - 3'd1 - {2'b00, info_q.mode == stack_byte_offset_mode ||
                      info_q.mode == stack_word_offset_mode};

    // operand bytes arrive high byte first for the word forms
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            op1_q <= 8'h00;
            op2_q <= 8'h00;
            lastOp_q <= 8'h00;
        end else if (st_q == S_OPND) begin
            lastOp_q <= busRdata;
            if (opLeft_q == nOpsInfo) op1_q <= busRdata;
            else op2_q <= busRdata;
        end
    end
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            pushIdx_q <= 3'd0;
            pushLast_q <= 3'd0;
            jumpPend_q <= 1'b0;
        end else begin
            if (takeIrq || st_q != S_PUSH && stNext == S_PUSH && cur.cls == C_SWI) begin
                pushIdx_q <= 3'd0;
                pushLast_q <= 3'd4;
            end else if (st_q != S_PUSH && stNext == S_PUSH) begin
                pushIdx_q <= (cur.cls == C_JSR) ? 3'd0 : (opc_q[3:0] == 4'h7 ||
                             st_q == S_FETCH && busRdata[3:0] == 4'h7) ? 3'd3 : 3'd2;
                pushLast_q <= (cur.cls == C_JSR) ? 3'd1 : (opc_q[3:0] == 4'h7 ||
                              st_q == S_FETCH && busRdata[3:0] == 4'h7) ? 3'd3 : 3'd2;
            end else if (st_q == S_PUSH) begin
                pushIdx_q <= pushIdx_q + 3'd1;
            end
            jumpPend_q <= (st_q == S_FETCH || st_q == S_OPND) && stNext == S_FREE &&
                          cur.cls == C_JMP;
        end
    end

    // ----------------------------------------
    // programmer registers
    // ----------------------------------------
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            pc_q <= 16'h0000;
        end else begin
            unique case (st_q)
                S_FETCH: if (!takeIrq) pc_q <= pc_q + 16'h0001; // [RULE6]
                S_OPND: pc_q <= (info_q.cls == C_BRA && opLeft_q == 3'd1 && brTaken) ?
                                pc_q + 16'h0001 + {{8{busRdata[7]}}, busRdata} : // [RULE12]
                                pc_q + 16'h0001;
                S_READ: if (info_q.cls == C_CBEQ && cbeqEq)
                            pc_q <= pc_q + {{8{lastOp_q[7]}}, lastOp_q}; // [RULE12]
                S_FREE: if (jumpPend_q) pc_q <= ea;
                S_PUSH: if (info_q.cls == C_JSR && pushIdx_q == pushLast_q) pc_q <= ea;
                S_VECHI: pc_q[15:8] <= busRdata; // [RULE11]
                S_VECLO: pc_q[7:0] <= busRdata; // [RULE11]
                default: pc_q <= pc_q;
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            sp_q <= `SP_RESET;
        end else if (st_q == S_PUSH) begin
            sp_q <= sp_q - 16'h0001; // [RULE9]
        end else if (st_q == S_POP) begin
            sp_q <= sp_q + 16'h0001; // [RULE10]
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            a_q <= 8'h00;
            hx_q <= 16'h0000;
        end else begin
            if (aluGo && opc_q[3:0] != 4'hE && opc_q[3:0] != 4'h1 && opc_q[3:0] != 4'h3 &&
                opc_q[3:0] != 4'h5) a_q <= res; // [RULE7]
            if (aluGo && opc_q[3:0] == 4'hE) hx_q[7:0] <= res;
            if (st_q == S_POP) begin
                if (opc_q[3:0] == 4'h6) a_q <= busRdata; // [RULE10]
                else hx_q[7:0] <= busRdata;
            end
            if (st_q == S_READ && info_q.cls == C_CBEQ) hx_q <= hx_q + 16'h0001; // [RULE1] [RULE2]
            if (st_q == S_FETCH && dec.cls == C_FLAG && !isPrefix && !takeIrq) begin
                if (busRdata[3:0] == 4'h7) hx_q[7:0] <= a_q;
                if (busRdata[3:0] == 4'hF) a_q <= hx_q[7:0];
            end
        end
    end

    // i is set once the flags byte is safely on the stack, so nested entry cannot slip in
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            flg_q <= `FLG_RESET;
        end else begin
            if (aluGo || st_q == S_WRITE) begin
                flg_q[`FLG_N] <= (st_q == S_WRITE) ? busOut.wdata[7] : res[7]; // [RULE15]
                flg_q[`FLG_Z] <= (st_q == S_WRITE) ? busOut.wdata == 8'h00 : res == 8'h00;
                flg_q[`FLG_V] <= aluGo && arith && src[7] == mm[7] && sum[7] != src[7];
                if (aluGo && arith) flg_q[`FLG_C] <= isSub ? !sum[8] : sum[8];
                if (aluGo && !isSub && arith) flg_q[`FLG_H] <= hsum[4];
            end
            if (st_q == S_FETCH && !isPrefix && !takeIrq) begin
                if (dec.cls == C_WAIT) flg_q[`FLG_I] <= 1'b0; // [RULE13]
                if (dec.cls == C_FLAG && busRdata[3:1] == 3'b100) flg_q[`FLG_C] <= busRdata[0];
                if (dec.cls == C_FLAG && busRdata[3:1] == 3'b101) flg_q[`FLG_I] <= busRdata[0];
            end
            if (st_q == S_PUSH && pushIdx_q == 3'd4) flg_q[`FLG_I] <= 1'b1;
        end
    end

    // ----------------------------------------
    // bus cycle outputs
    // ----------------------------------------
    always_comb begin
        busOut = '{pc_q, 8'h00, CYC_FREE, 1'b1, 1'b0}; // [RULE5]
        unique case (st_q)
            S_FETCH, S_OPND: busOut.code = CYC_FETCH; // [RULE6]
            S_READ: busOut = '{ea, 8'h00, CYC_READ, 1'b1, 1'b0}; // [RULE7]
            S_WRITE: busOut = '{ea, (opc_q[3:0] == 4'hF) ? hx_q[7:0] : a_q,
                                CYC_WRITE, 1'b0, 1'b1}; // [RULE8]
            S_PUSH: busOut = '{sp_q, (pushIdx_q == 3'd0) ? pc_q[7:0] :
                               (pushIdx_q == 3'd1) ? pc_q[15:8] : (pushIdx_q == 3'd2) ?
                               hx_q[7:0] : (pushIdx_q == 3'd3) ? a_q : flg_q,
                               CYC_PUSH, 1'b0, 1'b1}; // [RULE9]
            S_POP: busOut = '{sp_q + 16'h0001, 8'h00, CYC_POP, 1'b1, 1'b0}; // [RULE10]
            S_VECHI: busOut = '{{`VEC_PAGE, vecLo_q}, 8'h00, CYC_VECTOR, 1'b1, 1'b0};
            S_VECLO: busOut = '{{`VEC_PAGE, vecLo_q | 8'h01}, 8'h00, CYC_VECTOR, 1'b1, 1'b0};
            default: busOut.code = CYC_FREE;
        endcase
    end
    assign decodeOut = info_q;
    assign flagsOut = flg_q;
    assign halted = st_q == S_WAIT;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    free_is_read_a: assert property ( // [RULE5]
        busOut.code == CYC_FREE |-> busOut.rd && !busOut.wr)
        else $error("free cycle not a read");
    fetch_advance_a: assert property ( // [RULE6]
        st_q == S_FETCH && !takeIrq |=> pc_q == $past(pc_q) + 16'h0001)
        else $error("fetch did not advance pc");
    push_one_a: assert property ( // [RULE9]
        busOut.code == CYC_PUSH |-> busOut.wr && busOut.addr == sp_q
        ##1 sp_q == $past(sp_q) - 16'h0001)
        else $error("push not one byte at sp");
    pop_one_a: assert property ( // [RULE10]
        busOut.code == CYC_POP |-> busOut.rd && busOut.addr == sp_q + 16'h0001
        ##1 sp_q == $past(sp_q) + 16'h0001)
        else $error("pop not one byte above sp");
    vector_order_a: assert property ( // [RULE11]
        st_q == S_VECHI |-> busOut.addr[15:8] == 8'hFF
        ##1 st_q == S_VECLO && busOut.addr == $past(busOut.addr) + 16'h0001)
        else $error("vector not high then low");
    wait_unmask_a: assert property ($rose(halted) |-> !flg_q[`FLG_I]) // [RULE13]
        else $error("wait left mask set");
    post_inc_a: assert property ( // [RULE1]
        st_q == S_READ && info_q.cls == C_CBEQ |=> hx_q == $past(hx_q) + 16'h0001)
        else $error("index not incremented");
    stack_off_a: assert property ( // [RULE4]
        st_q == S_READ && info_q.mode == stack_byte_offset_mode
        |-> busOut.addr == sp_q + {8'h00, op1_q})
        else $error("stack offset address wrong");
    branch_rel_a: assert property ( // [RULE12]
        st_q == S_OPND && opLeft_q == 3'd1 && info_q.cls == C_BRA && brTaken
        |=> pc_q == $past(pc_q) + 16'h0001 + {{8{$past(busRdata[7])}}, $past(busRdata)})
        else $error("branch target wrong");

    swi_entry_c: cover property (info_q.cls == C_SWI && st_q == S_VECLO);
    wait_wake_c: cover property (halted ##1 !halted);
    cbeq_taken_c: cover property (st_q == S_READ && info_q.cls == C_CBEQ && cbeqEq);

endmodule : cpu_operand_and_bus_cycle_decode

`default_nettype wire

// file: bench/mem_model.sv
// zero-wait memory on the far side of the core's bus
// assumes the core presents one bus cycle per mclk edge
`default_nettype none

module mem_model import cpu_decode_pkg::*; (
    input wire logic mclk,
    input var busReq_t busIn,
    output logic [7:0] busRdata
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] mem [0:65535];
    logic [7:0] lastRead_q = 8'h00;

    // released data line shows the inverse so a stale byte cannot pass
    always @* begin
        busRdata = busIn.rd ? mem[busIn.addr] : ~lastRead_q;
    end

    always @(posedge mclk) begin
        if (busIn.rd) lastRead_q <= busRdata;
        if (busIn.wr) mem[busIn.addr] <= busIn.wdata;
    end
endmodule : mem_model

`default_nettype wire

// file: bench/cpu_operand_and_bus_cycle_decode_tb.sv
// bench: runs a short program and checks each bus cycle, halted ones as free reads and the rest against a queue
// assumes the memory model answers in the cycle of the request
`default_nettype none

module cpu_operand_and_bus_cycle_decode_tb import cpu_decode_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk = 1'b0;
    logic rst_n;
    logic irqReq;
    logic halted;
    logic [7:0] busRdata;
    logic [7:0] flagsOut;
    logic [7:0] r;
    busReq_t busOut;
    busReq_t e;
    busReq_t q[$];
    decode_t decodeOut;
    int err_count = 0;
    int n_compared = 0;
    int cycles = 0;
    logic [7:0] prog [14] = '{8'hC6, 8'h20, 8'h00, 8'hF7, 8'h87, 8'h86, 8'h20, 8'h00,
                              8'h9E, 8'hE6, 8'h11, 8'h71, 8'h00, 8'h8F};

    always #4 mclk = ~mclk;

    cpu_operand_and_bus_cycle_decode u_cpu_operand_and_bus_cycle_decode (.mclk(mclk),
        .rst_n(rst_n), .busRdata(busRdata), .irqReq(irqReq), .busOut(busOut),
        .decodeOut(decodeOut), .flagsOut(flagsOut), .halted(halted));
    mem_model u_mem_model (.mclk(mclk), .busIn(busOut), .busRdata(busRdata));

    task check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task ex(input logic [15:0] a, input logic [7:0] d, input cycle_t c);
        busReq_t t;
        t.addr = a;
        t.wdata = d;
        t.code = c;
        t.wr = (c == CYC_WRITE) || (c == CYC_PUSH);
        t.rd = !t.wr;
        q.push_back(t);
    endtask : ex

    task test_done;
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : test_done

    // ----------------------------------------
    // monitor: one expectation per bus cycle while not halted
    // ----------------------------------------
    always @(negedge mclk) begin
        if (rst_n === 1'b1 && halted === 1'b1) begin
            check(32'(busOut.code), 32'(CYC_FREE));
            check(32'(busOut.rd), 32'd1);
            check(32'(flagsOut[3]), 32'd0);
        end else if (rst_n === 1'b1 && q.size() > 0) begin
            e = q.pop_front();
            check(32'({busOut.code, busOut.rd, busOut.wr}), 32'({e.code, e.rd, e.wr}));
            if (e.code != CYC_FREE) check(32'(busOut.addr), 32'(e.addr));
            if (e.wr) check(32'(busOut.wdata), 32'(e.wdata));
            if (e.code == CYC_READ) check(32'({decodeOut.mode, decodeOut.len, decodeOut.cycles}),
                (e.addr == 16'h2000) ? 32'({full_address_mode, 3'd3, 4'd4}) :
                (e.addr == 16'h0110) ? 32'({stack_byte_offset_mode, 3'd3, 4'd4}) :
                32'({indexed_post_increment_mode, 3'd2, 4'd5}));
            if (e.code == CYC_WRITE) check(32'({decodeOut.mode, decodeOut.len, decodeOut.cycles}),
                32'({indexed_plain_mode, 3'd1, 4'd2}));
        end
    end

    // hang guard: the program needs well under a hundred cycles
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 2000) begin
            err_count++;
            test_done;
        end
    end

    initial begin
        rst_n = 1'b0;
        irqReq = 1'b0;
        void'($urandom(23996));
        r = 8'($urandom);
        u_mem_model.mem[16'hFFFE] = 8'h01;
        u_mem_model.mem[16'hFFFF] = 8'h00;
        u_mem_model.mem[16'hFFFA] = 8'h01;
        u_mem_model.mem[16'hFFFB] = 8'h00;
        u_mem_model.mem[16'h2000] = r;
        u_mem_model.mem[16'h0110] = r;
        for (int i = 0; i < 14; i++) u_mem_model.mem[16'h0100 + i] = prog[i];
        ex(16'hFFFE, 8'h00, CYC_VECTOR);
        ex(16'hFFFF, 8'h00, CYC_VECTOR);
        for (int i = 0; i < 3; i++) ex(16'h0100 + i, 8'h00, CYC_FETCH);
        ex(16'h2000, 8'h00, CYC_READ);
        ex(16'h0103, 8'h00, CYC_FETCH);
        ex(16'h0000, r, CYC_WRITE);
        ex(16'h0104, 8'h00, CYC_FETCH);
        ex(16'h00FF, r, CYC_PUSH);
        ex(16'h0105, 8'h00, CYC_FETCH);
        ex(16'h00FF, 8'h00, CYC_POP);
        ex(16'h0000, 8'h00, CYC_FREE);
        ex(16'h0106, 8'h00, CYC_FETCH);
        ex(16'h0107, 8'h00, CYC_FETCH);
        ex(16'h0000, 8'h00, CYC_FREE);
        for (int i = 8; i < 11; i++) ex(16'h0100 + i, 8'h00, CYC_FETCH);
        ex(16'h0110, 8'h00, CYC_READ);
        ex(16'h010B, 8'h00, CYC_FETCH);
        ex(16'h010C, 8'h00, CYC_FETCH);
        ex(16'h0000, 8'h00, CYC_READ);
        ex(16'h0000, 8'h00, CYC_FREE);
        ex(16'h0000, 8'h00, CYC_FREE);
        ex(16'h010D, 8'h00, CYC_FETCH);
        ex(16'h010E, 8'h00, CYC_FETCH);
        ex(16'h00FF, 8'h0E, CYC_PUSH);
        ex(16'h00FE, 8'h01, CYC_PUSH);
        ex(16'h00FD, 8'h01, CYC_PUSH);
        ex(16'h00FC, r, CYC_PUSH);
        ex(16'h00FB, {4'h6, 1'b0, r[7], r == 8'h00, 1'b0}, CYC_PUSH);
        ex(16'hFFFA, 8'h00, CYC_VECTOR);
        ex(16'hFFFB, 8'h00, CYC_VECTOR);
        repeat (2) @(posedge mclk);
        rst_n <= 1'b1;
        @(negedge mclk);
        check(32'(flagsOut), 32'h0000_0068);
        $display("test reset done");
        while (halted !== 1'b1) @(negedge mclk);
        repeat (1 + ($urandom % 4)) @(posedge mclk);
        irqReq <= 1'b1;
        while (q.size() > 0) @(posedge mclk);
        irqReq <= 1'b0;
        @(negedge mclk);
        check(32'(flagsOut[3]), 32'd1);
        $display("test program done");
        test_done;
    end
endmodule : cpu_operand_and_bus_cycle_decode_tb

`default_nettype wire
